/* File: shared/pll_load_pkg.sv */
`default_nettype none

package pll_load_pkg;

  localparam int REF_WIDTH   = 16;
  localparam int MAIN_WIDTH  = 10;
  localparam int CTRL_BITS   = 1;
  localparam int SHIFT_WIDTH = REF_WIDTH + CTRL_BITS;

  // Bit positions inside the shift chain; the control bit is the newest.
  localparam int CTRL_POS     = 0;
  localparam int PAYLOAD_LSB  = 1;

  localparam logic [REF_WIDTH-1:0]  MIN_REF_RATIO   = 16'h0005;
  localparam logic [MAIN_WIDTH-1:0] MIN_MAIN_RATIO  = 10'h005;
  localparam logic [REF_WIDTH-1:0]  REF_RATIO_RESET = 16'h0005;
  localparam logic [MAIN_WIDTH-1:0] MAIN_RATIO_RESET = 10'h005;
  localparam logic [SHIFT_WIDTH-1:0] SHIFT_RESET    = 17'h00000;

  localparam int SYNC_STAGES = 2;

endpackage : pll_load_pkg

`default_nettype wire

/* File: rtl/ratio_divider.sv */
`timescale 1ns/100ps
`default_nettype none

module ratio_divider
  import pll_load_pkg::*;
#(
  parameter int                 WIDTH       = REF_WIDTH,
  parameter logic [WIDTH-1:0]   RATIO_RESET = '1
) (
  input  wire logic             clk,          // System clock.
  input  wire logic             nrst,         // Asynchronous reset, active low.
  input  wire logic             freqIn,       // Pin to be divided, asynchronous.
  input  wire logic [WIDTH-1:0] ratio,        // Latched divide ratio.
  output logic                  divOut,       // Divided output, registered.
  output logic [WIDTH-1:0]      activeRatio   // Ratio of the running cycle.
);

  // A ratio of 5 needs three bits, so narrower counters are refused.
  if (WIDTH < 3) begin : g_badWidth
    $error("ratio_divider needs at least 3 bits to hold a ratio of 5.");
  end

  logic             syncA_reg;
  logic             syncB_reg;
  logic             prev_reg;
  logic [WIDTH-1:0] count_reg;
  logic [WIDTH-1:0] count_next;
  logic [WIDTH-1:0] active_reg;
  logic [WIDTH-1:0] active_next;
  logic             out_reg;
  logic             out_next;
  logic             edgeSeen;

  // Two flops before any logic looks at the pin.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      syncA_reg <= 1'b0;
      syncB_reg <= 1'b0;
      prev_reg  <= 1'b0;
    end else begin
      syncA_reg <= freqIn;
      syncB_reg <= syncA_reg;
      prev_reg  <= syncB_reg;
    end
  end

  assign edgeSeen = syncB_reg & ~prev_reg;

  always_comb begin
    count_next  = count_reg;
    active_next = active_reg;
    out_next    = out_reg;
    if (edgeSeen) begin
      if (count_reg == '0) begin
        // A new ratio is only taken here, never mid-cycle.
        active_next = ratio;
        count_next  = ratio - WIDTH'(1);
      end else begin
        count_next = count_reg - WIDTH'(1);
      end
      // High during the first half of the cycle, low for the rest.
      out_next = (count_next >= (active_next >> 1));
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      count_reg  <= '0;
      active_reg <= RATIO_RESET;
      out_reg    <= 1'b0;
    end else begin
      count_reg  <= count_next;
      active_reg <= active_next;
      out_reg    <= out_next;
    end
  end

  assign divOut      = out_reg;
  assign activeRatio = active_reg;

endmodule // ratio_divider

`default_nettype wire

/* File: rtl/pll_serial_divider_load.sv */
`timescale 1ns/100ps
`default_nettype none

module pll_serial_divider_load
  import pll_load_pkg::*;
#(
  parameter int REF_BITS  = REF_WIDTH,
  parameter int MAIN_BITS = MAIN_WIDTH
) (
  input  wire logic                 clk,                // System clock, 50 MHz.
  input  wire logic                 nrst,               // Asynchronous reset, active low.
  input  wire logic                 serialClk,          // Shift clock from the host.
  input  wire logic                 serialData,         // Serial data, MSB first.
  input  wire logic                 loadStrobe,         // Latch transfer, active high.
  input  wire logic                 crystalClockInput,  // Reference frequency pin.
  input  wire logic                 mainFreqInput,      // Frequency from the oscillator.
  output logic                      refDividedMonitor,  // Divided reference output.
  output logic                      mainDividedMonitor, // Divided main output.
  output logic [REF_BITS-1:0]       refRatio,           // Reference ratio latch.
  output logic [MAIN_BITS-1:0]      mainRatio,          // Main ratio latch.
  output logic [REF_BITS-1:0]       refActiveRatio,     // Ratio of running ref cycle.
  output logic [MAIN_BITS-1:0]      mainActiveRatio,    // Ratio of running main cycle.
  output logic                      refLoaded,          // Pulse: reference latch written.
  output logic                      mainLoaded,         // Pulse: main latch written.
  output logic                      ratioRejected       // Pulse: payload below 5 refused.
);

  // The word format fixes both widths, so any other value is refused here.
  if (REF_BITS != REF_WIDTH || MAIN_BITS != MAIN_WIDTH) begin : g_badWidth
    $error("Latch widths are fixed by the serial word format.");
  end

  // Serial clock domain: the shift chain.
  // The chain has no notion of a word boundary; only the newest bits count.

  logic [SHIFT_WIDTH-1:0] shift_reg;
  logic [SHIFT_WIDTH-1:0] shift_next;

  always_comb begin
    // Newest bit enters at the control position; older bits move up.
    shift_next = {shift_reg[SHIFT_WIDTH-2:0], serialData};
  end

  // The host's clock stops between words, so this domain does nothing
  // that must finish after the last edge of a word.
  always_ff @(posedge serialClk or negedge nrst) begin
    if (!nrst) begin
      shift_reg <= SHIFT_RESET;
    end else begin
      shift_reg <= shift_next;
    end
  end

  // System clock domain: strobe synchroniser.
  // The third flop only remembers the last synchronised level, so each
  // rise of the strobe is seen exactly once.

  logic strobeA_reg;
  logic strobeB_reg;
  logic strobePrev_reg;
  logic strobeRise;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      strobeA_reg    <= 1'b0;
      strobeB_reg    <= 1'b0;
      strobePrev_reg <= 1'b0;
    end else begin
      strobeA_reg    <= loadStrobe;
      strobeB_reg    <= strobeA_reg;
      strobePrev_reg <= strobeB_reg;
    end
  end

  assign strobeRise = strobeB_reg & ~strobePrev_reg;

  // Word crossing.
  // The chain is read here only while the synchronised strobe is high.
  // By then the host has stopped clocking for at least two system
  // cycles, so every bit is settled; a host that clocks while the
  // strobe is high gets no such guarantee.

  logic [SHIFT_WIDTH-1:0] word_reg;
  logic [SHIFT_WIDTH-1:0] word_next;
  logic                   wordValid_reg;
  logic                   wordValid_next;

  always_comb begin
    word_next      = word_reg;
    wordValid_next = 1'b0;
    if (strobeB_reg) begin
      word_next      = shift_reg;
      wordValid_next = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      word_reg      <= SHIFT_RESET;
      wordValid_reg <= 1'b0;
    end else begin
      word_reg      <= word_next;
      wordValid_reg <= wordValid_next;
    end
  end

  // Field extraction from the captured word.
  // Payloads below the minimum are refused here, so a divider never runs
  // with a ratio it cannot serve.

  logic                  ctrlBit;
  logic [REF_BITS-1:0]   refPayload;
  logic [MAIN_BITS-1:0]  mainPayload;
  logic                  refOk;
  logic                  mainOk;

  assign ctrlBit     = word_reg[CTRL_POS];
  assign refPayload  = word_reg[PAYLOAD_LSB +: REF_BITS];
  assign mainPayload = word_reg[PAYLOAD_LSB +: MAIN_BITS];
  assign refOk       = (refPayload >= MIN_REF_RATIO);
  assign mainOk      = (mainPayload >= MIN_MAIN_RATIO);

  // Latches.
  // Copying repeats on every cycle the strobe stays high; the value
  // is the same each time, so only the first cycle raises a pulse.
  // A refused payload leaves the latch untouched and only raises the refusal pulse.

  logic [REF_BITS-1:0]  refLatch_reg;
  logic [REF_BITS-1:0]  refLatch_next;
  logic [MAIN_BITS-1:0] mainLatch_reg;
  logic [MAIN_BITS-1:0] mainLatch_next;
  logic                 firstCycle_reg;
  logic                 firstCycle_next;
  logic                 refLoaded_reg;
  logic                 refLoaded_next;
  logic                 mainLoaded_reg;
  logic                 mainLoaded_next;
  logic                 rejected_reg;
  logic                 rejected_next;

  always_comb begin
    refLatch_next   = refLatch_reg;
    mainLatch_next  = mainLatch_reg;
    firstCycle_next = strobeRise;
    refLoaded_next  = 1'b0;
    mainLoaded_next = 1'b0;
    rejected_next   = 1'b0;
    if (wordValid_reg) begin
      if (ctrlBit) begin
        if (refOk) begin
          refLatch_next  = refPayload;
          refLoaded_next = firstCycle_reg;
        end else begin
          rejected_next = firstCycle_reg;
        end
      end else begin
        if (mainOk) begin
          mainLatch_next  = mainPayload;
          mainLoaded_next = firstCycle_reg;
        end else begin
          rejected_next = firstCycle_reg;
        end
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      refLatch_reg   <= REF_RATIO_RESET;
      mainLatch_reg  <= MAIN_RATIO_RESET;
      firstCycle_reg <= 1'b0;
      refLoaded_reg  <= 1'b0;
      mainLoaded_reg <= 1'b0;
      rejected_reg   <= 1'b0;
    end else begin
      refLatch_reg   <= refLatch_next;
      mainLatch_reg  <= mainLatch_next;
      firstCycle_reg <= firstCycle_next;
      refLoaded_reg  <= refLoaded_next;
      mainLoaded_reg <= mainLoaded_next;
      rejected_reg   <= rejected_next;
    end
  end

  // Dividers.
  // Each pin is sampled on the system clock, so it must run below half
  // that rate or edges are lost.

  ratio_divider #(
    .WIDTH       (REF_BITS),
    .RATIO_RESET (REF_RATIO_RESET)
  ) refDivider (
    .clk         (clk),
    .nrst        (nrst),
    .freqIn      (crystalClockInput),
    .ratio       (refLatch_reg),
    .divOut      (refDividedMonitor),
    .activeRatio (refActiveRatio)
  );

  ratio_divider #(
    .WIDTH       (MAIN_BITS),
    .RATIO_RESET (MAIN_RATIO_RESET)
  ) mainDivider (
    .clk         (clk),
    .nrst        (nrst),
    .freqIn      (mainFreqInput),
    .ratio       (mainLatch_reg),
    .divOut      (mainDividedMonitor),
    .activeRatio (mainActiveRatio)
  );

  assign refRatio      = refLatch_reg;
  assign mainRatio     = mainLatch_reg;
  assign refLoaded     = refLoaded_reg;
  assign mainLoaded    = mainLoaded_reg;
  assign ratioRejected = rejected_reg;

endmodule // pll_serial_divider_load

`default_nettype wire

/* File: bench/pll_load_sva.sv */
`timescale 1ns/100ps
`default_nettype none

module pll_load_sva
  import pll_load_pkg::*;
#(
  parameter int REF_BITS  = 16,
  parameter int MAIN_BITS = 10
) (
  input wire logic                 clk,             // System clock.
  input wire logic                 nrst,            // Reset, active low.
  input wire logic                 loadStrobe,      // Latch strobe.
  input wire logic [REF_BITS-1:0]  refRatio,        // Reference latch.
  input wire logic [MAIN_BITS-1:0] mainRatio,       // Main latch.
  input wire logic [REF_BITS-1:0]  refActiveRatio,  // Running ref ratio.
  input wire logic [MAIN_BITS-1:0] mainActiveRatio, // Running main ratio.
  input wire logic                 refLoaded,       // Ref latch pulse.
  input wire logic                 mainLoaded,      // Main latch pulse.
  input wire logic                 ratioRejected    // Refusal pulse.
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  sequence s_strobe_held; $rose(loadStrobe) ##1 loadStrobe [*2]; endsequence
  sequence s_answer; refLoaded || mainLoaded || ratioRejected; endsequence
  a_ref_quiet: assert property (!$stable(refRatio) |-> refLoaded)
    else $error("reference latch moved without a load");
  a_main_quiet: assert property (!$stable(mainRatio) |-> mainLoaded)
    else $error("main latch moved without a load");
  a_ref_min: assert property (refLoaded |-> refRatio >= MIN_REF_RATIO)
    else $error("reference ratio below minimum loaded");
  a_main_min: assert property (mainLoaded |-> mainRatio >= MIN_MAIN_RATIO)
    else $error("main ratio below minimum loaded");
  a_load_cause: assert property (s_answer |-> $past(loadStrobe, 3) || $past(loadStrobe, 4))
    else $error("latch pulse without a strobe");
  a_single_pulse: assert property (refLoaded || mainLoaded |=> !(refLoaded || mainLoaded))
    else $error("latch pulse longer than one cycle");
  a_one_latch: assert property (!(refLoaded && mainLoaded))
    else $error("both latches written at once");
  a_strobe_answer: assert property (s_strobe_held |-> ##[1:3] s_answer)
    else $error("strobe got no answer");
  a_ref_reload: assert property ($changed(refActiveRatio) |-> refActiveRatio == $past(refRatio))
    else $error("reference counter took a value not from its latch");
  a_main_reload: assert property ($changed(mainActiveRatio) |-> mainActiveRatio == $past(mainRatio))
    else $error("main counter took a value not from its latch");
endmodule // pll_load_sva

`default_nettype wire

/* File: bench/host_model.sv */
`timescale 1ns/100ps
`default_nettype none

module host_model
  import pll_load_pkg::*;
(
  input  wire logic clk,        // System clock, times the strobe.
  output logic      serialClk,  // Shift clock, still between frames.
  output logic      serialData, // Serial data, MSB first.
  output logic      loadStrobe  // Latch strobe.
);
  initial begin
    serialClk = 1'b0;
    serialData = 1'b0;
    loadStrobe = 1'b0;
  end
  // Data moves half a period before each rise, giving 16 ns of setup and hold.
  task automatic shift_word(input logic [15:0] v, input int n, input logic c);
    #7;
    for (int i = n; i >= 0; i--) begin
      if (i == 0) serialData = c;
      else serialData = v[i-1];
      #16 serialClk = 1'b1;
      #16 serialClk = 1'b0;
    end
    // The inverse is left on the line so a stale bit cannot pass for a good one.
    serialData = ~serialData;
  endtask
  task automatic strobe(input logic lvl);
    @(posedge clk);
    loadStrobe <= lvl;
  endtask
endmodule // host_model

`default_nettype wire

/* File: bench/tb.sv */
`timescale 1ns/100ps
`default_nettype none

module tb;
  import pll_load_pkg::*;
  logic        clk, nrst, serialClk, serialData, loadStrobe;
  logic        crystalClockInput, mainFreqInput, refDividedMonitor, mainDividedMonitor;
  logic [15:0] refRatio, refActiveRatio, expRef;
  logic [9:0]  mainRatio, mainActiveRatio, expMain;
  logic        refLoaded, mainLoaded, ratioRejected, gotRef, gotMain, gotRej;
  int          error_cnt, cmp_count, pinCnt;
  logic [15:0] tv [6] = '{16'hABCD, 16'h03FF, 16'h0004, 16'h0004, 16'h0005, 16'h0006};
  logic        tc [6] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1};

  host_model i_host_model (.clk(clk), .serialClk(serialClk), .serialData(serialData),
    .loadStrobe(loadStrobe));
  pll_serial_divider_load i_pll_serial_divider_load (.clk(clk), .nrst(nrst),
    .serialClk(serialClk), .serialData(serialData), .loadStrobe(loadStrobe),
    .crystalClockInput(crystalClockInput), .mainFreqInput(mainFreqInput),
    .refDividedMonitor(refDividedMonitor), .mainDividedMonitor(mainDividedMonitor),
    .refRatio(refRatio), .mainRatio(mainRatio), .refActiveRatio(refActiveRatio),
    .mainActiveRatio(mainActiveRatio), .refLoaded(refLoaded), .mainLoaded(mainLoaded),
    .ratioRejected(ratioRejected));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // Pins run at 8 and 10 clock periods, well under half the clock rate.
  always @(posedge clk) begin
    pinCnt <= (pinCnt == 19) ? 0 : pinCnt + 1;
    if (pinCnt % 4 == 3) crystalClockInput <= ~crystalClockInput;
    if (pinCnt % 5 == 4) mainFreqInput <= ~mainFreqInput;
  end

  task check(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task tally_and_finish;
    $display("compares=%0d errors=%0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic load_word(input logic [15:0] v, input logic c);
    i_host_model.shift_word(v, c ? REF_WIDTH : MAIN_WIDTH, c);
    i_host_model.strobe(1'b1);
    {gotRef, gotMain, gotRej} = 3'b000;
    repeat (10) begin
      @(posedge clk);
      #1;
      gotRef |= refLoaded === 1'b1;
      gotMain |= mainLoaded === 1'b1;
      gotRej |= ratioRejected === 1'b1;
    end
    i_host_model.strobe(1'b0);
    repeat (4) @(posedge clk);
    #1;
  endtask
  task automatic measure(input logic sel, input int exp);
    int   t[$];
    logic prev;
    logic cur;
    prev = 1'b1;
    for (int i = 0; i < 600 && t.size() < 3; i++) begin
      @(posedge clk);
      #1;
      cur = sel ? refDividedMonitor : mainDividedMonitor;
      if (cur === 1'b1 && prev === 1'b0) t.push_back(i);
      prev = cur;
    end
    if (t.size() < 3) begin
      error_cnt++;
      tally_and_finish();
    end else check(16'(t[2] - t[1]), 16'(exp));
  endtask

  initial begin
    {nrst, pinCnt, crystalClockInput, mainFreqInput, error_cnt, cmp_count} = '0;
    expRef = REF_RATIO_RESET;
    expMain = MAIN_RATIO_RESET;
    repeat (20) @(posedge clk);
    check({refLoaded, mainLoaded, ratioRejected, refDividedMonitor, mainDividedMonitor}, 16'h0000);
    check(refRatio, expRef);
    check(16'(mainRatio), 16'(expMain));
    nrst <= 1'b1;
    $display("test reset done");
    for (int k = 0; k < 6; k++) begin
      load_word(tv[k], tc[k]);
      if (tv[k] >= 16'h0005 && tc[k]) expRef = tv[k];
      else if (tv[k] >= 16'h0005) expMain = tv[k][9:0];
      check({gotRef, gotMain, gotRej}, {tv[k] >= 5 && tc[k], tv[k] >= 5 && !tc[k], tv[k] < 5});
      check(refRatio, expRef);
      check(mainRatio, expMain);
      $display("test load %0d done", k);
    end
    // A large ratio would stall the counters for ages, so reset clears them first.
    nrst <= 1'b0;
    repeat (3) @(posedge clk);
    check({mainRatio, refRatio[5:0]}, {MAIN_RATIO_RESET, REF_RATIO_RESET[5:0]});
    check(refRatio, REF_RATIO_RESET);
    nrst <= 1'b1;
    load_word(16'h0006, 1'b1);
    measure(1'b1, 48);
    measure(1'b0, 50);
    check(refActiveRatio, 16'h0006);
    check(16'(mainActiveRatio), 16'(MAIN_RATIO_RESET));
    $display("test dividers done");
    tally_and_finish();
  end
endmodule // tb

bind pll_serial_divider_load pll_load_sva #(.REF_BITS(REF_BITS), .MAIN_BITS(MAIN_BITS))
  i_pll_load_sva (.clk(clk), .nrst(nrst), .loadStrobe(loadStrobe), .refRatio(refRatio),
  .mainRatio(mainRatio), .refActiveRatio(refActiveRatio), .mainActiveRatio(mainActiveRatio),
  .refLoaded(refLoaded), .mainLoaded(mainLoaded), .ratioRejected(ratioRejected));

`default_nettype wire
